// *** logic/pch_device.sv ***
`timescale 1ns/100ps
module pch_device
(
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  pch_if.dev              link,
  input  wire logic       modeParallelOutBit,
  input  wire logic       modeDisplaySelectBit,
  input  wire logic       binaryMode,
  output logic [7:0]      cmdData,
  output logic            cmdValid,
  input  wire logic       cmdLast,
  input  wire logic       execDone,
  input  wire logic [7:0] rspData,
  input  wire logic       rspValid,
  output logic            rspReady,
  input  wire logic       rspLast
);

  // ------------------------------------------------------------------
  // State.
  // ------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    PCH_IDLE   = 3'b000,
    PCH_WAIT   = 3'b001,
    PCH_ACKED  = 3'b010,
    PCH_EXEC   = 3'b011,
    PCH_OPEND  = 3'b100,
    PCH_OSHOW  = 3'b101
  } pch_state_e;

  typedef struct packed
  {
    pch_state_e                   state;
    logic [pch_pkg::CNT_W-1:0]    count;
    logic                         busy;
    logic                         pendN;
    logic                         oe;
    logic [7:0]                   dout;
    logic [7:0]                   cmd;
    logic                         cmdV;
    logic                         last;
    logic                         lastOut;
  } pch_state_s;

  pch_state_s stateFf;
  pch_state_s nxtState;

  logic respAllowed;

  assign respAllowed = modeParallelOutBit && !modeDisplaySelectBit;
  assign rspReady    = (stateFf.state == PCH_OPEND) && !stateFf.pendN && !link.requestN;

  always_comb
  begin
    nxtState      = stateFf;
    nxtState.cmdV = 1'b0;
    case (stateFf.state)
      PCH_IDLE:
      begin
        nxtState.busy  = 1'b1;
        nxtState.oe    = 1'b0;
        if (respAllowed && rspValid)
        begin
          nxtState.pendN = 1'b0;
          nxtState.state = PCH_OPEND;
        end
        else if (!link.requestN)
        begin
          nxtState.count = '0;
          nxtState.state = PCH_WAIT;
        end
      end
      PCH_WAIT:
      begin
        // Slow acknowledge gives the host room before busy drops.
        if (stateFf.count == pch_pkg::CNT_W'(pch_pkg::ACK_DELAY_CYC - 1))
        begin
          nxtState.cmd   = link.busData;
          nxtState.cmdV  = 1'b1;
          nxtState.last  = cmdLast;
          nxtState.busy  = 1'b0;
          nxtState.state = PCH_ACKED;
        end
        else
        begin
          nxtState.count = stateFf.count + 1'b1;
        end
      end
      PCH_ACKED:
      begin
        if (link.requestN)
        begin
          if (stateFf.last)
          begin
            nxtState.state = PCH_EXEC;
          end
          else
          begin
            nxtState.busy  = 1'b1;
            nxtState.state = PCH_IDLE;
          end
        end
      end
      PCH_EXEC:
      begin
        // Busy held low while the command runs; a response may follow.
        if (respAllowed && rspValid)
        begin
          nxtState.busy  = 1'b1;
          nxtState.pendN = 1'b0;
          nxtState.state = PCH_OPEND;
        end
        else if (execDone)
        begin
          nxtState.busy  = 1'b1;
          nxtState.state = PCH_IDLE;
        end
      end
      PCH_OPEND:
      begin
        if (!respAllowed)
        begin
          nxtState.pendN = 1'b1;
          nxtState.state = PCH_IDLE;
        end
        else if (stateFf.pendN && rspValid)
        begin
          nxtState.pendN = 1'b0;
        end
        else if (!stateFf.pendN && !link.requestN && rspValid)
        begin
          nxtState.dout    = rspData;
          nxtState.oe      = 1'b1;
          nxtState.busy    = 1'b0;
          nxtState.lastOut = binaryMode ? 1'b1 : (rspData == pch_pkg::CHAR_CR);
          nxtState.state   = PCH_OSHOW;
        end
        else if (stateFf.pendN && execDone)
        begin
          nxtState.state = PCH_IDLE;
        end
      end
      PCH_OSHOW:
      begin
        if (link.requestN)
        begin
          nxtState.oe    = 1'b0;
          nxtState.busy  = 1'b1;
          nxtState.dout  = pch_pkg::DATA_RESET;
          if (stateFf.lastOut)
          begin
            nxtState.pendN = 1'b1;
          end
          nxtState.state = PCH_OPEND;
        end
      end
      default:
      begin
        nxtState.state = PCH_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stateFf.state   <= PCH_IDLE;
      stateFf.count   <= '0;
      stateFf.busy    <= 1'b1;
      stateFf.pendN   <= 1'b1;
      stateFf.oe      <= 1'b0;
      stateFf.dout    <= pch_pkg::DATA_RESET;
      stateFf.cmd     <= pch_pkg::DATA_RESET;
      stateFf.cmdV    <= 1'b0;
      stateFf.last    <= 1'b0;
      stateFf.lastOut <= 1'b0;
    end
    else
    begin
      stateFf <= nxtState;
    end
  end

  assign link.busy           = stateFf.busy;
  assign link.outputPendingN = stateFf.pendN;
  assign link.devData        = stateFf.dout;
  assign link.devDataOe      = stateFf.oe;
  assign cmdData             = stateFf.cmd;
  assign cmdValid            = stateFf.cmdV;

endmodule

// *** logic/pch_host.sv ***
`timescale 1ns/100ps
module pch_host
(
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  pch_if.host             link,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady,
  output logic [7:0]      rxData,
  output logic            rxValid
);

  // ------------------------------------------------------------------
  // State.
  // ------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PCHH_IDLE = 2'b00,
    PCHH_SEND = 2'b01,
    PCHH_RECV = 2'b10,
    PCHH_DONE = 2'b11
  } pchh_state_e;

  typedef struct packed
  {
    pchh_state_e state;
    logic        reqN;
    logic        oe;
    logic [7:0]  dout;
    logic [7:0]  rx;
    logic        rxV;
  } pchh_state_s;

  pchh_state_s stateFf;
  pchh_state_s nxtState;

  // Output from the device has priority: low pending means the bus is its.
  assign txReady = (stateFf.state == PCHH_IDLE) && link.busy && link.outputPendingN;

  always_comb
  begin
    nxtState     = stateFf;
    nxtState.rxV = 1'b0;
    case (stateFf.state)
      PCHH_IDLE:
      begin
        if (!link.outputPendingN && link.busy)
        begin
          nxtState.reqN  = 1'b0;
          nxtState.state = PCHH_RECV;
        end
        else if (txValid && txReady)
        begin
          nxtState.dout  = txData;
          nxtState.oe    = 1'b1;
          nxtState.reqN  = 1'b0;
          nxtState.state = PCHH_SEND;
        end
      end
      PCHH_SEND:
      begin
        if (!link.busy)
        begin
          nxtState.reqN  = 1'b1;
          nxtState.oe    = 1'b0;
          nxtState.state = PCHH_DONE;
        end
      end
      PCHH_RECV:
      begin
        if (!link.busy)
        begin
          nxtState.rx    = link.busData;
          nxtState.rxV   = 1'b1;
          nxtState.reqN  = 1'b1;
          nxtState.state = PCHH_DONE;
        end
      end
      PCHH_DONE:
      begin
        // Wait for busy to return before another handshake.
        if (link.busy)
        begin
          nxtState.state = PCHH_IDLE;
        end
      end
      default:
      begin
        nxtState.state = PCHH_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stateFf.state <= PCHH_IDLE;
      stateFf.reqN  <= 1'b1;
      stateFf.oe    <= 1'b0;
      stateFf.dout  <= 8'h00;
      stateFf.rx    <= 8'h00;
      stateFf.rxV   <= 1'b0;
    end
    else
    begin
      stateFf <= nxtState;
    end
  end

  assign link.requestN   = stateFf.reqN;
  assign link.hostData   = stateFf.dout;
  assign link.hostDataOe = stateFf.oe;
  assign rxData          = stateFf.rx;
  assign rxValid         = stateFf.rxV;

endmodule

// *** pkg/pch_if.sv ***
`timescale 1ns/100ps
interface pch_if;
  logic       requestN;
  logic       busy;
  logic       outputPendingN;
  logic [7:0] devData;
  logic       devDataOe;
  logic [7:0] hostData;
  logic       hostDataOe;
  logic [7:0] busData;

  // Undriven bus reads as all ones through pull-ups.
  assign busData = devDataOe ? devData : (hostDataOe ? hostData : 8'hff);

  modport dev
  (
    input  requestN,
    output busy,
    output outputPendingN,
    output devData,
    output devDataOe,
    input  busData
  );

  modport host
  (
    output requestN,
    input  busy,
    input  outputPendingN,
    output hostData,
    output hostDataOe,
    input  busData
  );
endinterface

// *** pkg/pch_pkg.sv ***
package pch_pkg;

  // ------------------------------------------------------------------
  // Timing.
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned ACK_DELAY_US    = 25;
  localparam int unsigned ACK_DELAY_CYC   = (ACK_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned EXEC_DELAY_CYC  = 4 * ACK_DELAY_CYC;
  localparam int unsigned CNT_W           = 16;

  // ------------------------------------------------------------------
  // Data layout.
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W          = 8;
  localparam logic [7:0]  CHAR_CR         = 8'h0d;
  localparam logic [7:0]  DATA_RESET      = 8'h00;

endpackage

// *** sim/pch_chk.sv ***
`timescale 1ns/100ps
module pch_chk
(
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       requestN,
  input wire logic       busy,
  input wire logic       outputPendingN,
  input wire logic       devDataOe,
  input wire logic [7:0] hostData,
  input wire logic       hostDataOe
);
  // ------
  // Handshake checks.
  // ------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // The acknowledge takes thousands of cycles, too long for a delay range, so it is counted here.
  localparam logic [15:0] ACK_LO = 16'((pch_pkg::ACK_DELAY_CYC * 95) / 100);
  localparam logic [15:0] ACK_HI = 16'((pch_pkg::ACK_DELAY_CYC * 105) / 100);

  logic [15:0] ackCnt;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ackCnt <= 16'h0000;
    end
    else if ($fell(requestN) && outputPendingN)
    begin
      ackCnt <= 16'h0001;
    end
    else if ((ackCnt != 16'h0000) && busy)
    begin
      ackCnt <= ackCnt + 16'h0001;
    end
    else
    begin
      ackCnt <= 16'h0000;
    end
  end

  sequence cmdStrobe;
    $fell(requestN) && outputPendingN;
  endsequence
  sequence slowAck;
    busy ? (ackCnt <= ACK_HI) : (ackCnt >= ACK_LO);
  endsequence
  a_reset_idle: assert property ($rose(arst_n) |-> busy && outputPendingN && !devDataOe)
    else $error("state after reset wrong");
  a_host_waits: assert property ($fell(requestN) |-> busy)
    else $error("strobe while busy low");
  a_host_holds: assert property (cmdStrobe ##0 (!requestN && busy) |=> !requestN && $stable(hostData))
    else $error("host let go early");
  a_ack_slow: assert property ((ackCnt != 16'h0000) |-> slowAck)
    else $error("acknowledge delay wrong");
  a_strobe_back: assert property ($fell(busy) && outputPendingN |-> ##[1:4] requestN)
    else $error("strobe not raised");
  a_pend_first: assert property ($rose(devDataOe) |-> $past(outputPendingN) == 1'b0)
    else $error("data before pending");
  a_drive_gate: assert property (devDataOe |-> !busy && !outputPendingN)
    else $error("bus driven outside answer");
  a_bus_release: assert property (devDataOe && requestN |-> ##[1:2] (!devDataOe && busy))
    else $error("bus not released");
  a_one_driver: assert property (!(devDataOe && hostDataOe))
    else $error("two bus drivers");
endmodule

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
  logic       sys_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       modeParallelOutBit = 1'b1;
  logic       modeDisplaySelectBit = 1'b0;
  logic       binaryMode = 1'b0;
  logic [7:0] cmdData;
  logic       cmdValid;
  logic       cmdLast = 1'b0;
  logic       execDone = 1'b0;
  logic [7:0] rspData = 8'h00;
  logic       rspValid = 1'b0;
  logic       rspReady;
  logic [7:0] txData = 8'h00;
  logic       txValid = 1'b0;
  logic       txReady;
  logic [7:0] rxData;
  logic       rxValid;
  logic [7:0] gotRx;
  int         rxCnt = 0;
  int         rxBase = 0;
  int         n_mismatch = 0;
  int         comparisons = 0;

  pch_if link ();
  pch_device u_pch_device (.sys_clk, .arst_n, .link(link.dev), .modeParallelOutBit, .modeDisplaySelectBit,
    .binaryMode, .cmdData, .cmdValid, .cmdLast, .execDone, .rspData, .rspValid, .rspReady, .rspLast(1'b0));
  pch_host u_pch_host (.sys_clk, .arst_n, .link(link.host), .txData, .txValid, .txReady, .rxData, .rxValid);
  pch_chk u_pch_chk (.sys_clk, .arst_n, .requestN(link.requestN), .busy(link.busy),
    .outputPendingN(link.outputPendingN), .devDataOe(link.devDataOe), .hostData(link.hostData),
    .hostDataOe(link.hostDataOe));

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    if (rxValid === 1'b1)
    begin
      gotRx <= rxData;
      rxCnt <= rxCnt + 1;
    end
  end

  // ------
  // Scenarios.
  // ------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return txReady;
      1: return cmdValid;
      2: return link.busy;
      3: return rspReady;
      default: return logic'(rxCnt != rxBase);
    endcase
  endfunction

  // The bound covers one slow acknowledge with margin, so a hang shows as one mismatch.
  task automatic waitFor(input int k, input logic v);
    for (int i = 0; i < 4000 && sig(k) !== v; i++) @(negedge sys_clk);
    check({7'h00, sig(k)}, {7'h00, v}, "handshake");
  endtask

  task automatic send(input logic [7:0] b, input logic last);
    @(negedge sys_clk);
    txData = b;
    txValid = 1'b1;
    cmdLast = last;
    waitFor(0, 1'b1);
    @(negedge sys_clk);
    txValid = 1'b0;
    waitFor(1, 1'b1);
    check(cmdData, b, "command byte");
    check({7'h00, link.busy}, 8'h00, "ack");
    @(negedge sys_clk);
    cmdLast = 1'b0;
  endtask

  task automatic put(input logic [7:0] b, input logic pend);
    @(negedge sys_clk);
    rspData = b;
    rspValid = 1'b1;
    rxBase = rxCnt;
    waitFor(3, 1'b1);
    @(negedge sys_clk);
    rspValid = 1'b0;
    waitFor(4, 1'b1);
    check(gotRx, b, "response byte");
    waitFor(2, 1'b1);
    check({7'h00, link.outputPendingN}, {7'h00, pend}, "pending");
  endtask

  task automatic t_command();
    send(8'h4e, 1'b0);
    waitFor(2, 1'b1);
    send(8'h35, 1'b1);
    repeat (100) @(negedge sys_clk);
    check({7'h00, link.busy}, 8'h00, "exec busy");
    execDone = 1'b1;
    @(negedge sys_clk);
    execDone = 1'b0;
    waitFor(2, 1'b1);
    $display("test command done");
  endtask

  task automatic t_refuse();
    for (int i = 0; i < 4; i++)
    begin
      if (i != 2)
      begin
        @(negedge sys_clk);
        {modeParallelOutBit, modeDisplaySelectBit} = 2'(i);
        rspValid = 1'b1;
        repeat (50) @(negedge sys_clk);
        check({6'h00, link.outputPendingN, rspReady}, 8'h02, "refused");
        rspValid = 1'b0;
      end
    end
    @(negedge sys_clk);
    {modeParallelOutBit, modeDisplaySelectBit} = 2'b10;
    $display("test refuse done");
  endtask

  task automatic t_response();
    put(8'h50, 1'b0);
    put(8'h0d, 1'b1);
    binaryMode = 1'b1;
    put(8'h0d, 1'b1);
    put(8'h41, 1'b1);
    $display("test response done");
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
    check({6'h00, link.busy, link.outputPendingN}, 8'h03, "reset");
    check(link.busData, 8'hff, "bus");
    t_command();
    t_refuse();
    t_response();
    results();
  end

  initial
  begin
    #(80 * pch_pkg::ACK_DELAY_CYC);
    n_mismatch++;
    results();
  end
endmodule
